// *** sequencer_map.svh ***
`ifndef SEQUENCER_MAP_SVH
`define SEQUENCER_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain port)
// ----------------------------------------------------------------
`define REG_CONFIG 8'h00
`define REG_CONTROL 8'h04
`define REG_INTERVAL 8'h08
`define REG_LIST_LAST 8'h0C
`define REG_SAMPLE_COUNT 8'h10
`define REG_STATUS 8'h14
`define REG_SAMPLE_DATA 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CFG_EXT_CLOCK_BIT 0
`define CFG_LIST_CLOCK_BIT 1
`define CFG_TRIG_LSB 2
`define CFG_TRIG_MSB 3
`define CTL_START_BIT 0
`define CTL_STOP_BIT 1
`define STS_ACTIVE_BIT 0
`define STS_ARMED_BIT 1
`define STS_FRESH_BIT 2
`define STS_GROUP_LSB 4
`define STS_GROUP_MSB 7
`define STS_DONE_LSB 16
`define STS_DONE_MSB 31

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_EXT_CLOCK 1'h0
`define RST_LIST_CLOCK 1'h1
`define RST_TRIG_MODE 2'h0
`define RST_INTERVAL 16'h0064
`define RST_LIST_LAST 4'h1
`define RST_SAMPLE_COUNT 16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define SYNC_LATENCY_NS 200
`define SYNC_LATENCY_CYCLES (`SYNC_LATENCY_NS / `CLK_PERIOD_NS)

`endif

// *** sequencer_pkg.sv ***
package sequencer_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ARMED = 2'h1,
		ST_PACE = 2'h3,
		ST_LIST = 2'h2
	} seq_state_e;

	typedef enum logic [1:0] {
		TRIG_OFF = 2'h0,
		TRIG_SINGLE = 2'h1,
		TRIG_GATED = 2'h2
	} trig_mode_e;

	typedef struct packed {
		logic meta;
		logic level;
		logic level_d;
		logic rise;
	} sync_s;

	typedef struct packed {
		seq_state_e state;
		logic ext_clock_enable;
		logic list_clock_select;
		logic [1:0] trigger_mode_select;
		logic [15:0] interval;
		logic [3:0] list_last;
		logic [15:0] sample_count;
		logic [15:0] done_count;
		logic [3:0] group;
		logic [15:0] timer;
		logic convert_strobe;
		logic [3:0] convert_group;
		logic [15:0] sample_data;
		logic sample_fresh;
		logic sampling_active;
		logic [31:0] rd_data;
	} seq_s;

endpackage : sequencer_pkg

// *** edge_sync.sv ***
`timescale 1ns/1ns

module edge_sync (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic pin,
	output logic level,
	output logic rise
);

	sequencer_pkg::sync_s r;
	sequencer_pkg::sync_s next_r;

	// Only the second stage reads the first; edge logic looks at stages two and three
	always_comb begin
		next_r = r;
		next_r.meta = pin;
		next_r.level = r.meta;
		next_r.level_d = r.level;
		next_r.rise = r.level & ~r.level_d;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign level = r.level;
	assign rise = r.rise;

endmodule : edge_sync

// *** sample_clock_trigger_sequencer.sv ***
//
// Overview of operation
// - Whole-list mode: each clock edge converts list
// - First group on edge, rest interval spaced
// - No maximum external clock period
// - Single-group mode: one group per edge
// - After last entry, wrap to first
// - Converted value readable from the next cycle
// - No trailing flush cycle after stop
// - Trigger mode: single-shot, gated, off default
// - Single-shot holds off until trigger high
// - Run until stop or sample count
// - First conversion aligned to trigger edge
// - Gated: sample while high, stop low
// - Whole-list gate-off waits for list end
// - Single-group gate-off at group end
// - Gated restart aligned like single-shot
// - Triggered external clock starts next edge
// - Clock style selectable, whole-list default
// - Synchronization latency under 200 ns
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "sequencer_map.svh"

module sample_clock_trigger_sequencer (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic ext_clock_pin,
	input wire logic trigger_pin,
	input wire logic [15:0] adc_data,
	input wire logic adc_valid,
	output logic convert_strobe,
	output logic [3:0] convert_group,
	output logic sampling_active
);

	// ----------------------------------------------------------------
	// Pin synchronizers
	// ----------------------------------------------------------------
	logic ext_level;
	logic ext_rise;
	logic trig_level;
	logic trig_rise;

	// Both pins come from outside the clock domain
	// Rise reaches the state machine three cycles after the pin, far inside the latency bound
	edge_sync u_ext_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin(ext_clock_pin),
		.level(ext_level),
		.rise(ext_rise)
	);

	edge_sync u_trig_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin(trigger_pin),
		.level(trig_level),
		.rise(trig_rise)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sequencer_pkg::seq_s r;
	sequencer_pkg::seq_s next_r;

	logic fire;
	logic trig_ok;
	logic gated;
	logic whole_list;
	logic last_entry;
	logic stop_req;
	logic start_req;
	logic [15:0] done_next;

	always_comb begin
		next_r = r;
		fire = 1'b0;
		trig_ok = 1'b0;
		gated = 1'b0;
		whole_list = 1'b0;
		last_entry = 1'b0;
		stop_req = 1'b0;
		start_req = 1'b0;
		done_next = 16'h0000;
		next_r.convert_strobe = 1'b0;
		next_r.rd_data = 32'h00000000;

		// ------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------
		if (wr_en) begin
			unique case (addr)
				`REG_CONFIG: begin
					next_r.ext_clock_enable = wr_data[`CFG_EXT_CLOCK_BIT];
					next_r.list_clock_select = wr_data[`CFG_LIST_CLOCK_BIT];
					next_r.trigger_mode_select = wr_data[`CFG_TRIG_MSB:`CFG_TRIG_LSB];
				end
				`REG_CONTROL: begin
					start_req = wr_data[`CTL_START_BIT];
					stop_req = wr_data[`CTL_STOP_BIT];
				end
				`REG_INTERVAL: begin
					next_r.interval = wr_data[15:0];
				end
				`REG_LIST_LAST: begin
					next_r.list_last = wr_data[3:0];
				end
				`REG_SAMPLE_COUNT: begin
					// Zero leaves the run without a count limit
					next_r.sample_count = wr_data[15:0];
				end
				default: ;
			endcase
		end

		// ------------------------------------------------------------
		// Register reads, answered one cycle later
		// ------------------------------------------------------------
		if (rd_en) begin
			unique case (addr)
				`REG_CONFIG: begin
					next_r.rd_data[`CFG_EXT_CLOCK_BIT] = r.ext_clock_enable;
					next_r.rd_data[`CFG_LIST_CLOCK_BIT] = r.list_clock_select;
					next_r.rd_data[`CFG_TRIG_MSB:`CFG_TRIG_LSB] = r.trigger_mode_select;
				end
				`REG_INTERVAL: begin
					next_r.rd_data[15:0] = r.interval;
				end
				`REG_LIST_LAST: begin
					next_r.rd_data[3:0] = r.list_last;
				end
				`REG_SAMPLE_COUNT: begin
					next_r.rd_data[15:0] = r.sample_count;
				end
				`REG_STATUS: begin
					next_r.rd_data[`STS_ACTIVE_BIT] = r.sampling_active;
					next_r.rd_data[`STS_ARMED_BIT] = (r.state == sequencer_pkg::ST_ARMED);
					next_r.rd_data[`STS_FRESH_BIT] = r.sample_fresh;
					next_r.rd_data[`STS_GROUP_MSB:`STS_GROUP_LSB] = r.group;
					next_r.rd_data[`STS_DONE_MSB:`STS_DONE_LSB] = r.done_count;
				end
				`REG_SAMPLE_DATA: begin
					next_r.rd_data[15:0] = r.sample_data;
					next_r.sample_fresh = 1'b0;
				end
				default: ;
			endcase
		end

		// ------------------------------------------------------------
		// Sample capture
		// ------------------------------------------------------------
		// Single stage: the value lands in the readable register as it arrives
		// A new value in the cycle of a read wins, so fresh never drops a sample
		if (adc_valid) begin
			next_r.sample_data = adc_data;
			next_r.sample_fresh = 1'b1;
		end

		// ------------------------------------------------------------
		// Sequencing
		// ------------------------------------------------------------
		if (r.timer != 16'h0000) begin
			next_r.timer = r.timer - 16'h0001;
		end

		// ------------------------------------------------------------
		// Trigger qualification
		// ------------------------------------------------------------
		// Level, not edge, releases the armed state; code three acts as off
		gated = (r.trigger_mode_select == sequencer_pkg::TRIG_GATED);
		whole_list = r.ext_clock_enable & r.list_clock_select;
		last_entry = (r.group == r.list_last);
		unique case (r.trigger_mode_select)
			sequencer_pkg::TRIG_SINGLE: trig_ok = trig_level;
			sequencer_pkg::TRIG_GATED: trig_ok = trig_level;
			default: trig_ok = 1'b1;
		endcase

		// ------------------------------------------------------------
		// Run state machine
		// ------------------------------------------------------------
		unique case (r.state)
			sequencer_pkg::ST_IDLE: begin
				// Nothing converts until software starts a run
			end
			sequencer_pkg::ST_ARMED: begin
				if (trig_ok) begin
					if (r.ext_clock_enable) begin
						// Wait for the first clock edge after the trigger
						next_r.state = sequencer_pkg::ST_PACE;
					end else begin
						// Internal pacing converts on the trigger itself
						fire = 1'b1;
					end
				end
			end
			sequencer_pkg::ST_PACE: begin
				// Here a group or a whole list has just ended, or an external-clock run waits for its first edge
				if (gated & ~trig_level) begin
					next_r.state = sequencer_pkg::ST_ARMED;
				end else if (r.ext_clock_enable) begin
					// No time-out: waits on the edge forever
					fire = ext_rise;
				end else begin
					fire = (r.timer == 16'h0000);
				end
			end
			sequencer_pkg::ST_LIST: begin
				// Gate is not looked at inside a list
				fire = (r.timer == 16'h0000);
			end
		endcase

		// ------------------------------------------------------------
		// Stop
		// ------------------------------------------------------------
		// A stop drops the run at once with no flush conversion
		if (stop_req) begin
			fire = 1'b0;
			next_r.state = sequencer_pkg::ST_IDLE;
		end

		// ------------------------------------------------------------
		// Conversion launch
		// ------------------------------------------------------------
		if (fire) begin
			done_next = r.done_count + 16'h0001;
			next_r.convert_strobe = 1'b1;
			next_r.convert_group = r.group;
			next_r.done_count = done_next;
			// Interval of zero behaves as one cycle
			next_r.timer = (r.interval == 16'h0000) ? 16'h0000 : r.interval - 16'h0001;
			next_r.group = last_entry ? 4'h0 : r.group + 4'h1;
			if (whole_list & ~last_entry) begin
				next_r.state = sequencer_pkg::ST_LIST;
			end else begin
				next_r.state = sequencer_pkg::ST_PACE;
			end
			// Count limit ends the run on its last conversion
			if ((r.sample_count != 16'h0000) && (done_next == r.sample_count)) begin
				next_r.state = sequencer_pkg::ST_IDLE;
			end
		end

		// ------------------------------------------------------------
		// Run start
		// ------------------------------------------------------------
		// A start while running is ignored: software must stop first
		if (start_req & ~stop_req & (r.state == sequencer_pkg::ST_IDLE)) begin
			next_r.state = sequencer_pkg::ST_ARMED;
			next_r.group = 4'h0;
			next_r.done_count = 16'h0000;
			next_r.timer = 16'h0000;
		end

		next_r.sampling_active = (next_r.state != sequencer_pkg::ST_IDLE);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset restores the default modes and settings
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
			r.state <= sequencer_pkg::ST_IDLE;
			r.ext_clock_enable <= `RST_EXT_CLOCK;
			r.list_clock_select <= `RST_LIST_CLOCK;
			r.trigger_mode_select <= `RST_TRIG_MODE;
			r.interval <= `RST_INTERVAL;
			r.list_last <= `RST_LIST_LAST;
			r.sample_count <= `RST_SAMPLE_COUNT;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a field of the state register
	assign rd_data = r.rd_data;
	assign convert_strobe = r.convert_strobe;
	assign convert_group = r.convert_group;
	assign sampling_active = r.sampling_active;

endmodule : sample_clock_trigger_sequencer

// *** seq_chk.sv ***
`timescale 1ns/1ns
`include "sequencer_map.svh"

module seq_chk (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [31:0] rd_data,
	input wire logic ext_clock_pin,
	input wire logic trigger_pin,
	input wire logic [15:0] adc_data,
	input wire logic adc_valid,
	input wire logic convert_strobe,
	input wire logic [3:0] convert_group,
	input wire logic sampling_active
);
	// ----
	// Shadow of mode and list, kept from bus writes
	// ----
	logic [3:0] cfg;
	logic [3:0] last;
	logic seen;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg <= 4'h2;
			last <= 4'h1;
			seen <= 1'b0;
		end else begin
			if (wr_en && addr == `REG_CONFIG)
				cfg <= wr_data[3:0];
			if (wr_en && addr == `REG_LIST_LAST)
				last <= wr_data[3:0];
			seen <= sampling_active && (seen || convert_strobe);
		end
	end
	AST_FIRST_GROUP: assert property (convert_strobe && !seen |-> convert_group == 4'h0)
		else $error("first strobe of a run is not group zero");
	AST_GROUP_WRAP: assert property (convert_strobe && seen |->
		convert_group == ($past(convert_group) == last ? 4'h0 : $past(convert_group) + 4'h1))
		else $error("group sequence broken");
	AST_GROUP_HOLD: assert property (!convert_strobe |-> $stable(convert_group))
		else $error("group changed without strobe");
	AST_EXT_ONLY: assert property (cfg[1:0] == 2'h1 && convert_strobe |-> $past(ext_clock_pin, 3))
		else $error("single-group strobe without clock edge");
	AST_SYNC_BOUND: assert property (cfg == 4'h1 && sampling_active && $rose(ext_clock_pin) |-> ##[1:20] convert_strobe)
		else $error("clock edge not converted within sync latency");
	AST_STOP: assert property (wr_en && addr == `REG_CONTROL && wr_data[1] |=> (!sampling_active && !convert_strobe) [*3])
		else $error("activity after stop");
	AST_TRIG_HOLD: assert property (cfg[3:2] == 2'h1 && convert_strobe && !seen |-> $past(trigger_pin, 2))
		else $error("conversion before trigger");
	AST_SAMPLE: assert property (adc_valid ##1 (rd_en && addr == `REG_SAMPLE_DATA) |=> rd_data[15:0] == $past(adc_data, 2))
		else $error("sample not readable next cycle");
endmodule : seq_chk

bind sample_clock_trigger_sequencer seq_chk chk (.sys_clk, .sys_rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
	.ext_clock_pin, .trigger_pin, .adc_data, .adc_valid, .convert_strobe, .convert_group, .sampling_active);

// *** ext_source.sv ***
`timescale 1ns/1ns

module ext_source (
	output logic ext_clock_pin,
	output logic trigger_pin
);
	initial begin
		ext_clock_pin = 1'b0;
		trigger_pin = 1'b0;
	end
	// Clock stands low between pulses; gap stretches the period past interval plus sync latency
	task automatic clk_pulses(input int n, input int gap_ns);
		// Start off the system clock edge so the pin never races the sampling flop
		#3;
		repeat (n) begin
			ext_clock_pin = 1'b1;
			#63;
			ext_clock_pin = 1'b0;
			#(62 + gap_ns);
		end
	endtask : clk_pulses
	// Held 100 ns: above minimum high, under single-conversion maximum, ahead of clock setup
	task automatic trig_set(input logic v);
		#3;
		trigger_pin = v;
		#100;
	endtask : trig_set
endmodule : ext_source

// *** sample_clock_trigger_sequencer_tb.sv ***
`timescale 1ns/1ns
`include "sequencer_map.svh"

module sample_clock_trigger_sequencer_tb;
	logic sys_clk = 1'b0;
	logic sys_rst;
	logic [7:0] addr;
	logic [31:0] wr_data;
	logic wr_en;
	logic rd_en;
	logic [15:0] adc_data;
	logic adc_valid;
	logic [31:0] rd_data;
	logic ext_clock_pin;
	logic trigger_pin;
	logic convert_strobe;
	logic [3:0] convert_group;
	logic sampling_active;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int t0;
	int n;
	logic [3:0] grp[$];
	int tim[$];

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (convert_strobe === 1'b1) begin
			grp.push_back(convert_group);
			tim.push_back(cyc);
		end
	end

	ext_source src (.ext_clock_pin(ext_clock_pin), .trigger_pin(trigger_pin));
	sample_clock_trigger_sequencer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_clock_pin(ext_clock_pin), .trigger_pin(trigger_pin),
		.adc_data(adc_data), .adc_valid(adc_valid), .convert_strobe(convert_strobe), .convert_group(convert_group),
		.sampling_active(sampling_active));

	// ----
	// Bus and checking helpers
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic w(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : w
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 chk(rd_data, exp);
		@(posedge sys_clk);
	endtask : rd
	task automatic go(input logic [3:0] c);
		wr(`REG_CONFIG, {28'h0, c});
		grp.delete();
		tim.delete();
		wr(`REG_CONTROL, 32'h1);
		w(5);
	endtask : go
	// Lists here always hold three groups; gap 0 skips spacing checks
	task automatic seq_q(input int k, input int gap);
		for (int i = 0; i < k; i++) begin
			chk(32'(grp[i]), 32'(i % 3));
			if (gap > 0 && i % 3 != 0)
				chk(32'(tim[i] - tim[i - 1]), 32'(gap));
		end
		chk(32'(grp.size()), 32'(k));
	endtask : seq_q

	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		rd(`REG_CONFIG, 32'h2);
		rd(8'h1C, 32'h0);
		adc_data <= 16'hA5C3;
		adc_valid <= 1'b1;
		@(posedge sys_clk);
		adc_valid <= 1'b0;
		rd(`REG_SAMPLE_DATA, 32'hA5C3);
	endtask : t_regs
	task automatic t_internal();
		wr(`REG_INTERVAL, 32'h3);
		wr(`REG_LIST_LAST, 32'h2);
		wr(`REG_SAMPLE_COUNT, 32'h4);
		go(4'h2);
		w(30);
		seq_q(4, 3);
		chk(32'(sampling_active), 32'h0);
		rd(`REG_STATUS, 32'h00040010);
		wr(`REG_SAMPLE_COUNT, 32'h0);
	endtask : t_internal
	task automatic t_ext();
		go(4'h3);
		src.clk_pulses(2, 400);
		w(10);
		seq_q(6, 3);
		wr(`REG_CONTROL, 32'h2);
		go(4'h1);
		src.clk_pulses(4, 150);
		w(300);
		src.clk_pulses(1, 150);
		w(10);
		seq_q(5, 0);
		wr(`REG_CONTROL, 32'h2);
	endtask : t_ext
	task automatic t_single_shot();
		go(4'h6);
		w(30);
		chk(32'(grp.size()), 32'h0);
		t0 = cyc;
		src.trig_set(1'b1);
		w(10);
		chk(32'(tim.size() > 0), 32'h1);
		chk(32'(tim[0] - t0 < 20), 32'h1);
		wr(`REG_CONTROL, 32'h2);
		n = grp.size();
		w(10);
		chk(32'(grp.size()), 32'(n));
		src.trig_set(1'b0);
	endtask : t_single_shot
	task automatic t_gated();
		go(4'hA);
		w(20);
		chk(32'(grp.size()), 32'h0);
		src.trig_set(1'b1);
		w(10);
		src.trig_set(1'b0);
		w(20);
		n = grp.size();
		chk(32'(n > 0), 32'h1);
		w(20);
		chk(32'(grp.size()), 32'(n));
		src.trig_set(1'b1);
		w(10);
		chk(32'(grp.size() > n), 32'h1);
		wr(`REG_CONTROL, 32'h2);
		src.trig_set(1'b0);
		go(4'h5);
		src.clk_pulses(2, 150);
		chk(32'(grp.size()), 32'h0);
		src.trig_set(1'b1);
		src.clk_pulses(1, 150);
		w(10);
		chk(32'(grp.size()), 32'h1);
		wr(`REG_CONTROL, 32'h2);
		src.trig_set(1'b0);
		wr(`REG_INTERVAL, 32'h40);
		go(4'hA);
		src.trig_set(1'b1);
		src.trig_set(1'b0);
		w(20);
		chk(32'(grp.size()), 32'h1);
		wr(`REG_CONTROL, 32'h2);
	endtask : t_gated

	task automatic test_done();
		if (err_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	initial begin
		sys_rst <= 1'b1;
		addr <= 8'h00;
		wr_data <= 32'h00000000;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		adc_data <= 16'h0000;
		adc_valid <= 1'b0;
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		t_regs();
		t_internal();
		t_ext();
		t_single_shot();
		t_gated();
		test_done();
	end
	// Whole run is about 10.4 us; this limit leaves ample margin
	initial begin
		#300000;
		err_count++;
		test_done();
	end
endmodule : sample_clock_trigger_sequencer_tb
